//--- hw/eewp_map.vh
// Constants for the parallel EEPROM write and protection controller.
`ifndef EEWP_MAP_VH
`define EEWP_MAP_VH
`define EEWP_CLK_PERIOD_NS 5
`define EEWP_STROBE_NS 200
`define EEWP_STROBE_CYC ((`EEWP_STROBE_NS + `EEWP_CLK_PERIOD_NS - 1) / `EEWP_CLK_PERIOD_NS)
`define EEWP_GLITCH_NS 20
`define EEWP_BYTE_GAP_US 30
`define EEWP_BYTE_GAP_CYC ((`EEWP_BYTE_GAP_US * 1000) / `EEWP_CLK_PERIOD_NS)
`define EEWP_HOLD_MS 10
`define EEWP_HOLD_CYC ((`EEWP_HOLD_MS * 1000000) / `EEWP_CLK_PERIOD_NS)
`define EEWP_ADDR_UNLOCK 17'h05555
`define EEWP_ADDR_ALT_A 17'h0aaaa
`define EEWP_ADDR_ALT_B 17'h02aaa
`define EEWP_DATA_AA 8'haa
`define EEWP_DATA_55 8'h55
`define EEWP_DATA_PROT 8'ha0
`define EEWP_DATA_80 8'h80
`define EEWP_DATA_CANCEL 8'h20
`define EEWP_OP_WRITE 2'h0
`define EEWP_OP_READ 2'h1
`define EEWP_OP_PROT 2'h2
`define EEWP_OP_UNPROT 2'h3
`endif

//--- hw/eewp_seq_rom.v
// Small table of command-prefix address/data pairs.
`timescale 1ns/100ps
module eewp_seq_rom (
  input wire clk_i,
  input wire rst_i,
  input wire [2:0] idx_i,
  input wire cancel_i,
  output reg [16:0] addr_o,
  output reg [7:0] data_o
);
`include "eewp_map.vh"
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_o <= 17'h00000;
      data_o <= 8'h00;
    end else begin
      case (idx_i)
        3'h0, 3'h3: begin
          addr_o <= `EEWP_ADDR_UNLOCK;
          data_o <= `EEWP_DATA_AA;
        end
        3'h1, 3'h4: begin
          addr_o <= `EEWP_ADDR_ALT_B;
          data_o <= `EEWP_DATA_55;
        end
        3'h2: begin
          addr_o <= `EEWP_ADDR_UNLOCK;
          data_o <= cancel_i ? `EEWP_DATA_80 : `EEWP_DATA_PROT;
        end
        default: begin
          addr_o <= `EEWP_ADDR_UNLOCK;
          data_o <= `EEWP_DATA_CANCEL;
        end
      endcase
    end
  end
endmodule // eewp_seq_rom

//--- hw/eewp_ctrl.v
// Host controller driving a parallel EEPROM with write protection.
// Function
// R1: Device holds busy output released except during internal write.
// R2: Device releases busy output when the internal write completes.
// R3: Device ignores reads and writes while hold-off input is low.
// R4: Host holds hold-off high throughout all read and write activity.
// R5: Hold-off falling mid-programming aborts it; host avoids that.
// R6: Host keeps hold-off high 10 ms after the last written byte.
// R7: Device filters control pulses of 20 ns or less.
// R8: Host drives hold-off low while reset, covering power transitions.
// R9: Under protection the host prefixes each write with three bytes.
// R10: Three-byte prefix while unprotected enters protection mode.
// R11: Cancel is six writes 5555/AA 2AAA/55 5555/80 5555/AA 2AAA/55 5555/20.
// R12: Cancel-sequence bytes are not programmed into the array.
// R13: After cancel, plain writes are accepted without prefix.
// R14: Reading during a write gives inverted bit seven of last byte.
// R15: Each page byte follows the previous within 30 microseconds.
// R16: Address taken on strobe fall, data on the later rising edge.
// R17: Protection prefix is 5555/AA 2AAA/55 5555/A0.
`timescale 1ns/100ps
`include "eewp_map.vh"
module eewp_ctrl #(
  parameter HOLD_CYC = `EEWP_HOLD_CYC
) (
  input wire clk_i,
  input wire rst_i,
  input wire cmd_valid_i,
  input wire [1:0] cmd_op_i,
  input wire [16:0] cmd_addr_i,
  input wire [7:0] cmd_data_i,
  input wire cmd_last_i,
  input wire prot_mode_i,
  output wire cmd_ready_o,
  output reg rd_valid_o,
  output reg [7:0] rd_data_o,
  output reg busy_o,
  output reg [16:0] byte_address_lines_o,
  output reg [7:0] dq_o,
  output reg dq_oe_o,
  input wire [7:0] dq_i,
  output reg ce_n_o,
  output reg oe_n_o,
  output reg we_n_o,
  output reg hold_off_input_n_o,
  input wire rdy_busy_n_i
);
  // ****************************************************************
  // Constants and state
  // ****************************************************************
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_STROBE = 2'h1;
  localparam [1:0] ST_GAP = 2'h2;
  localparam [1:0] ST_HOLD = 2'h3;
  localparam [7:0] STROBE_CYC = `EEWP_STROBE_CYC;
  reg [1:0] state_reg;
  reg [7:0] strobe_cnt_reg;
  reg [12:0] gap_cnt_reg;
  reg [31:0] hold_cnt_reg;
  reg [2:0] pre_idx_reg;
  reg [2:0] pre_left_reg;
  reg cancel_reg;
  reg is_read_reg;
  reg last_reg;
  reg [16:0] addr_reg;
  reg [7:0] data_reg;
  reg rdy_s1_reg;
  reg rdy_s2_reg;
  reg [7:0] dq_s1_reg;
  reg [7:0] dq_s2_reg;
  reg prot_op_reg;
  reg pay_reg;
  wire [16:0] rom_addr;
  wire [7:0] rom_data;
  wire pre_active;
  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdy_s1_reg <= 1'b1;
      rdy_s2_reg <= 1'b1;
      dq_s1_reg <= 8'h00;
      dq_s2_reg <= 8'h00;
    end else begin
      rdy_s1_reg <= rdy_busy_n_i;
      rdy_s2_reg <= rdy_s1_reg;
      // Read data settles long before the strobe ends, so two stages are free.
      dq_s1_reg <= dq_i;
      dq_s2_reg <= dq_s1_reg;
    end
  end
  eewp_seq_rom u_rom (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .idx_i(pre_idx_reg),
    .cancel_i(cancel_reg),
    .addr_o(rom_addr),
    .data_o(rom_data)
  );
  assign pre_active = (pre_left_reg != 3'h0);
  // Commands wait while a prefix is running or the part is programming.
  assign cmd_ready_o = (state_reg == ST_IDLE) && !pre_active &&
                       rdy_s2_reg && (hold_cnt_reg == 32'h0); // R1 R2
  // ****************************************************************
  // Bus sequencer
  // ****************************************************************
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      strobe_cnt_reg <= 8'h00;
      gap_cnt_reg <= 13'h0000;
      hold_cnt_reg <= 32'h0;
      pre_idx_reg <= 3'h0;
      pre_left_reg <= 3'h0;
      cancel_reg <= 1'b0;
      is_read_reg <= 1'b0;
      last_reg <= 1'b0;
      prot_op_reg <= 1'b0;
      pay_reg <= 1'b0;
      addr_reg <= 17'h00000;
      data_reg <= 8'h00;
      rd_valid_o <= 1'b0;
      rd_data_o <= 8'h00;
      busy_o <= 1'b0;
      byte_address_lines_o <= 17'h00000;
      dq_o <= 8'h00;
      dq_oe_o <= 1'b0;
      ce_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      we_n_o <= 1'b1;
      hold_off_input_n_o <= 1'b0; // R8
    end else begin
      rd_valid_o <= 1'b0;
      hold_off_input_n_o <= 1'b1; // R4
      busy_o <= !rdy_s2_reg || (hold_cnt_reg != 32'h0) ||
                (state_reg != ST_IDLE) || pre_active;
      if (hold_cnt_reg != 32'h0) begin
        hold_cnt_reg <= hold_cnt_reg - 32'h1; // R5 R6
      end
      case (state_reg)
        ST_IDLE: begin
          if (cmd_valid_i && cmd_ready_o) begin
            addr_reg <= cmd_addr_i;
            data_reg <= cmd_data_i;
            last_reg <= cmd_last_i;
            is_read_reg <= (cmd_op_i == `EEWP_OP_READ);
            cancel_reg <= (cmd_op_i == `EEWP_OP_UNPROT);
            prot_op_reg <= (cmd_op_i == `EEWP_OP_PROT);
            // Only reads and writes own a payload strobe after any prefix.
            pay_reg <= (cmd_op_i == `EEWP_OP_WRITE) ||
                       (cmd_op_i == `EEWP_OP_READ);
            pre_idx_reg <= 3'h0;
            if (cmd_op_i == `EEWP_OP_UNPROT) begin
              pre_left_reg <= 3'h6; // R11 R12
            end else if (cmd_op_i == `EEWP_OP_PROT ||
                         (cmd_op_i == `EEWP_OP_WRITE && prot_mode_i)) begin
              pre_left_reg <= 3'h3; // R9 R10 R17
            end else begin
              pre_left_reg <= 3'h0; // R13
            end
            // Prefix-only commands carry no payload byte afterwards.
            state_reg <= ST_GAP;
            gap_cnt_reg <= 13'h0002;
          end
        end
        ST_GAP: begin
          if (gap_cnt_reg != 13'h0000) begin
            gap_cnt_reg <= gap_cnt_reg - 13'h0001;
          end else begin
            // Address and data change on the same edge as the strobe falls, and are held until it rises.
            ce_n_o <= 1'b0; // R16
            strobe_cnt_reg <= STROBE_CYC;
            state_reg <= ST_STROBE;
            if (pre_active) begin
              byte_address_lines_o <= rom_addr;
              dq_o <= rom_data;
              dq_oe_o <= 1'b1;
              we_n_o <= 1'b0;
            end else begin
              byte_address_lines_o <= addr_reg;
              dq_o <= data_reg;
              dq_oe_o <= !is_read_reg;
              we_n_o <= is_read_reg;
              oe_n_o <= !is_read_reg;
            end
          end
        end
        ST_STROBE: begin
          // Strobes far longer than 20 ns so the part's filter passes them.
          if (strobe_cnt_reg != 8'h00) begin
            strobe_cnt_reg <= strobe_cnt_reg - 8'h01; // R7
          end else begin
            ce_n_o <= 1'b1; // R16
            we_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            state_reg <= ST_HOLD;
            if (pre_active) begin
              pre_left_reg <= pre_left_reg - 3'h1;
              pre_idx_reg <= pre_idx_reg + 3'h1;
            end else begin
              pay_reg <= 1'b0;
              if (is_read_reg) begin
                rd_valid_o <= 1'b1;
                rd_data_o <= dq_s2_reg; // R14
              end
            end
          end
        end
        ST_HOLD: begin
          dq_oe_o <= 1'b0;
          // A write behind a prefix still owes its payload strobe.
          if (pre_active || pay_reg) begin
            state_reg <= ST_GAP;
            gap_cnt_reg <= 13'h0002; // R15
          end else begin
            state_reg <= ST_IDLE;
            // The timer also covers the status pin's synchroniser delay.
            if (!is_read_reg && (last_reg || cancel_reg ||
                prot_op_reg)) begin
              hold_cnt_reg <= HOLD_CYC; // R6
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // eewp_ctrl

//--- tb/eewp_properties.sv
// Pin checker for the EEPROM host controller.
`timescale 1ns/100ps
module eewp_properties (
  input wire clk_i,
  input wire rst_i,
  input wire ce_n_o,
  input wire oe_n_o,
  input wire we_n_o,
  input wire dq_oe_o,
  input wire [7:0] dq_o,
  input wire [16:0] byte_address_lines_o,
  input wire hold_off_input_n_o,
  input wire rd_valid_o,
  input wire rdy_busy_n_i
);
  // ****
  // Properties
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sel_hold_a: assert property (!ce_n_o |-> hold_off_input_n_o)
    else $error("select with hold-off low");
  hold_keep_a: assert property (!$fell(hold_off_input_n_o))
    else $error("hold-off fell");
  strobe_wide_a: assert property ($fell(we_n_o) |-> !we_n_o [*5])
    else $error("short strobe");
  wr_drive_a: assert property (!we_n_o |-> dq_oe_o && oe_n_o)
    else $error("write not driven");
  addr_hold_a: assert property (!ce_n_o [*2] |->
    $stable(byte_address_lines_o)) else $error("address moved");
  data_hold_a: assert property (!we_n_o [*2] |-> $stable(dq_o))
    else $error("data moved");
  busy_wait_a: assert property (!rdy_busy_n_i [*3] |-> !$fell(we_n_o))
    else $error("write while busy");
  cmd_addr_a: assert property ($fell(we_n_o) &&
    dq_o inside {8'ha0, 8'h80, 8'h20} |-> byte_address_lines_o == 17'h05555)
    else $error("prefix address");
  cover property ($fell(we_n_o) && dq_o == 8'h20);
  cover property (rd_valid_o);
  cover property (!rdy_busy_n_i ##1 rdy_busy_n_i);
endmodule // eewp_properties
bind eewp_ctrl eewp_properties u_props (.clk_i(clk_i), .rst_i(rst_i),
  .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o), .dq_oe_o(dq_oe_o),
  .dq_o(dq_o), .byte_address_lines_o(byte_address_lines_o),
  .hold_off_input_n_o(hold_off_input_n_o), .rd_valid_o(rd_valid_o),
  .rdy_busy_n_i(rdy_busy_n_i));

//--- tb/eewp_mem_model.sv
// Behavioural EEPROM facing the controller pins.
`timescale 1ns/100ps
module eewp_mem_model #(
  parameter PROG_CYC = 60
) (
  input wire clk_i,
  input wire [16:0] addr_i,
  input wire [7:0] dq_i,
  input wire ce_n_i,
  input wire we_n_i,
  input wire oe_n_i,
  input wire hold_n_i,
  output reg [7:0] dq_o,
  output reg rdy_busy_n_o
);
  // ****
  // Device
  // ****
  localparam [47:0] SEQ = 48'haa55_80aa_5520;
  reg [7:0] mem [int];
  reg [7:0] last_reg = 8'h00;
  reg [16:0] a_reg = 17'h0;
  reg ce_reg = 1, we_reg = 1, prot_reg = 0, arm_reg = 0;
  integer s = 0, busy = 0, wl = 0;
  reg ok;
  // A released status pin reads as its pull-up level.
  initial rdy_busy_n_o = 1'b1;
  initial dq_o = 8'h5a;
  always @(posedge clk_i) begin
    if (busy > 0) busy = hold_n_i ? busy - 1 : 0;
    if (we_reg && !we_n_i) a_reg = addr_i;
    if (!we_reg && we_n_i && !ce_reg && hold_n_i && wl > 4) begin
      ok = ((s == 1 || s == 4) ? (a_reg == 17'h0aaaa || a_reg == 17'h02aaa)
        : a_reg == 17'h05555) && (dq_i == SEQ[47 - 8 * s -: 8] ||
        (s == 2 && dq_i == 8'ha0));
      if (ok && s == 2 && dq_i == 8'ha0) begin
        {prot_reg, arm_reg, s} = {2'b11, 32'd0};
      end else if (ok && s == 5) begin
        {prot_reg, s} = {1'b0, 32'd0};
      end else if (ok) begin
        s = s + 1;
      end else begin
        s = 0;
        if (!prot_reg || arm_reg) begin
          mem[a_reg] = dq_i;
          last_reg = dq_i;
          arm_reg = 1'b0;
          busy = PROG_CYC;
        end
      end
    end
    wl = we_n_i ? 0 : wl + 1;
    {we_reg, ce_reg} = {we_n_i, ce_n_i};
    rdy_busy_n_o <= (busy == 0);
    // Undriven lines toggle so a stale byte never reads as valid.
    dq_o <= (!ce_n_i && !oe_n_i && hold_n_i) ? (busy > 0 ?
      {~last_reg[7], 7'h00} : mem.exists(addr_i) ? mem[addr_i] : 8'hff)
      : ~dq_o;
  end
endmodule // eewp_mem_model

//--- tb/test_eewp_ctrl.sv
// Self-checking bench for the EEPROM host controller.
`timescale 1ns/100ps
module test_eewp_ctrl;
  reg clk_i = 0, rst_i = 1, v = 0, pm = 0;
  reg [1:0] op = 0;
  reg [16:0] a = 0, ad;
  reg [7:0] d = 0, dt;
  reg [31:0] seed = 53147, r;
  reg [7:0] expq [$];
  integer error_cnt = 0, samples_checked = 0, i;
  wire rdy, rv, oe, ce_n, oe_n, we_n, hold_n, rb_n, bsy;
  wire [7:0] rdat, dq, mq;
  wire [16:0] ma;
  eewp_ctrl #(.HOLD_CYC(20)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .cmd_valid_i(v), .cmd_op_i(op), .cmd_addr_i(a), .cmd_data_i(d),
    .cmd_last_i(1'b1), .prot_mode_i(pm), .cmd_ready_o(rdy),
    .rd_valid_o(rv), .rd_data_o(rdat), .busy_o(bsy), .byte_address_lines_o(ma),
    .dq_o(dq), .dq_oe_o(oe), .dq_i(mq), .ce_n_o(ce_n), .oe_n_o(oe_n),
    .we_n_o(we_n), .hold_off_input_n_o(hold_n), .rdy_busy_n_i(rb_n));
  eewp_mem_model u_mem (.clk_i(clk_i), .addr_i(ma), .dq_i(oe ? dq : ~dq),
    .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .hold_n_i(hold_n),
    .dq_o(mq), .rdy_busy_n_o(rb_n));
  // ****
  // Tasks
  // ****
  initial forever #2.5 clk_i = ~clk_i;
  function automatic [31:0] rnd;
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed;
  endfunction
  task automatic chk(input bit ok, input string m);
    samples_checked++;
    if (!ok) begin
      error_cnt++;
      $display("ERROR at %0t: %s", $time, m);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_rdy;
    integer n;
    for (n = 0; rdy !== 1'b1 && n < 40000; n++) @(negedge clk_i);
    if (n == 40000) begin
      chk(0, "ready timeout");
      wrap_up;
    end
  endtask
  // The request stays up until the edge that takes it.
  task automatic cmd(input [1:0] o, input [16:0] x, input [7:0] y, input p);
    wait_rdy;
    {op, a, d, pm, v} = {o, x, y, p, 1'b1};
    @(posedge clk_i);
    @(negedge clk_i);
    v = 0;
    repeat (4) @(negedge clk_i);
    chk(bsy === 1'b1, "busy flag");
    wait_rdy;
  endtask
  task automatic rd(input [16:0] x, input [7:0] e);
    expq.push_back(e);
    cmd(1, x, 8'h00, 0);
  endtask
  always @(negedge clk_i) if (rv === 1'b1) begin
    if (expq.size() == 0) chk(0, "unexpected read");
    else chk(rdat === expq.pop_front(), "read data");
  end
  // ****
  // Scenarios
  // ****
  initial begin
    repeat (8) @(posedge clk_i);
    @(negedge clk_i) rst_i = 0;
    repeat (3) @(negedge clk_i);
    for (i = 0; i < 3; i++) begin
      r = rnd();
      // Odd data and high addresses keep payload apart from command bytes.
      ad = {1'b1, r[15:0]};
      dt = r[23:16] | 8'h01;
      cmd(0, ad, dt, 0);
      rd(ad, dt);
      cmd(2, 17'h0, 8'h00, 0);
      chk(u_mem.prot_reg === 1'b1, "protect");
      cmd(0, ad, dt ^ 8'h04, 1);
      rd(ad, dt ^ 8'h04);
      cmd(0, ad, dt ^ 8'h02, 0);
      rd(ad, dt ^ 8'h04);
      cmd(3, 17'h0, 8'h00, 0);
      chk(u_mem.prot_reg === 1'b0, "unprotect");
      rd(17'h05555, 8'hff);
    end
    repeat (100) @(negedge clk_i);
    chk(expq.size() == 0, "reads missing");
    wrap_up;
  end
endmodule // test_eewp_ctrl
